// ==== design/ppc_pin_cell.sv ====
// Decode of one pin's mode into pad controls and the data read bit
`default_nettype none

module ppc_pin_cell
   import ppc_pkg::*;
(
   // Configuration
   input  wire ppc_pkg::ppc_mode_e mode,
   input  wire logic               data_bit,
   input  wire logic               alt_bit,
   // Pad state
   input  wire logic               pin_level,
   input  wire logic               standby,
   input  wire logic               keep_in_stby,
   input  wire logic               input_only,
   // Pad controls and the data read bit
   output logic                    drv_val,
   output logic                    drv_oe,
   output logic                    pull_up,
   output logic                    pull_dn,
   output logic                    ttl_lvl,
   output logic                    analog,
   output logic                    rd_bit
);

   // Mode table, then standby and input-only overrides
   always_comb begin
      drv_val = 1'b0;
      drv_oe  = 1'b0;
      pull_up = 1'b0;
      pull_dn = 1'b0;
      ttl_lvl = 1'b0;
      analog  = 1'b0;
      rd_bit  = pin_level;
      case (mode)
         MODE_ANALOG: begin
            analog = 1'b1;
            rd_bit = 1'b0;
         end
         MODE_TTL_FLOAT: begin
            ttl_lvl = 1'b1;
         end
         MODE_CMOS_FLOAT: begin
            ttl_lvl = 1'b0;
         end
         MODE_IN_PULL: begin
            pull_up = data_bit;
            pull_dn = ~data_bit;
         end
         MODE_OUT_OD: begin
            drv_oe = ~data_bit;
         end
         MODE_OUT_PP: begin
            drv_oe  = 1'b1;
            drv_val = data_bit;
            rd_bit  = data_bit;
         end
         MODE_ALT_OD: begin
            drv_oe = ~alt_bit;
         end
         MODE_ALT_PP: begin
            drv_oe  = 1'b1;
            drv_val = alt_bit;
         end
         default: begin
            analog = 1'b1;
            rd_bit = 1'b0;
         end
      endcase
      // Standby releases pad completely, keepers excepted
      if (standby && !keep_in_stby) begin
         drv_oe  = 1'b0;
         pull_up = 1'b0;
         pull_dn = 1'b0;
      end
      // Wake pin has no driver at all
      if (input_only) begin
         drv_oe = 1'b0;
      end
   end

endmodule : ppc_pin_cell

`default_nettype wire

// ==== design/ppc_pkg.sv ====
// Constants, register map and mode encoding of the port pin configuration block
//
// Behaviour
// - Mode 0,0,1 makes the pin a floating TTL input; reads give the pin, writes do not reach it.
// - Mode 0,1,0 makes the pin a floating CMOS input; reads give the pin, writes do not reach it.
// - Mode 0,1,1 with data bit 0 makes the pin a CMOS input with weak pull-down; reads give the pin.
// - Mode 0,1,1 with data bit 1 makes the pin a CMOS input with weak pull-up; reads give the pin.
// - Mode 0,0,0 makes the pin an analog input with no digital path; reads give 0.
// - Mode 1,0,0 drives the pin open-drain from the data bit; reads give the pin level.
// - Mode 1,0,1 drives the pin push-pull from the data bit; reads give the last value written.
// - Mode 1,1,0 lets the alternate function drive open-drain; reads give the pin level.
// - Mode 1,1,1 lets the alternate function drive push-pull; reads give the pin level.
// - Alternate function on pins shared with the two-wire bus goes to the two-wire bus by default.
// - Alternate function on pins shared with the UART goes to the UART by default.
// - Only once software sets the serial-port enable bit do shared pins carry the serial port.
// - In standby every pin is high impedance except pins kept active in standby.
// - The wake pin is input only and its active level in standby raises a wake request.
`default_nettype none

package ppc_pkg;

   // ==========================================================
   // Sizes
   localparam int PORT_WIDTH = 16;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_CFG0   = 8'h00;
   localparam logic [7:0] OFF_CFG1   = 8'h04;
   localparam logic [7:0] OFF_CFG2   = 8'h08;
   localparam logic [7:0] OFF_DATA   = 8'h0c;
   localparam logic [7:0] OFF_BOOT   = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;

   // ==========================================================
   // Field positions
   localparam int BOOT_SPI_EN_BIT = 0;
   localparam int STAT_STBY_BIT   = 0;
   localparam int STAT_WAKE_BIT   = 1;

   // ==========================================================
   // Reset values: every pin comes up as an input with pull-up
   localparam logic [15:0] RST_CFG0 = 16'hffff;
   localparam logic [15:0] RST_CFG1 = 16'hffff;
   localparam logic [15:0] RST_CFG2 = 16'h0000;
   localparam logic [15:0] RST_DATA = 16'hffff;
   localparam logic        RST_BOOT_SPI_EN = 1'b0;

   // ==========================================================
   // Default pin assignments
   localparam logic [15:0] DFLT_UART_SHARED = 16'h0003;
   localparam logic [15:0] DFLT_TWI_SHARED  = 16'h000c;
   localparam logic [15:0] DFLT_STBY_KEEP   = 16'h0000;
   localparam int          DFLT_WAKE_PIN    = 15;
   localparam logic        DFLT_WAKE_LEVEL  = 1'b1;

   // ==========================================================
   // Pin mode, bits are {cfg2, cfg1, cfg0}
   typedef enum logic [2:0] {
      MODE_ANALOG     = 3'b000,
      MODE_TTL_FLOAT  = 3'b001,
      MODE_CMOS_FLOAT = 3'b010,
      MODE_IN_PULL    = 3'b011,
      MODE_OUT_OD     = 3'b100,
      MODE_OUT_PP     = 3'b101,
      MODE_ALT_OD     = 3'b110,
      MODE_ALT_PP     = 3'b111
   } ppc_mode_e;

endpackage : ppc_pkg

`default_nettype wire

// ==== design/ppc_port.sv ====
// GPIO port with per-pin mode, alternate-function routing, standby and wake
//
// Implementation choices: the register addresses and register access over Wishbone.
`default_nettype none

module ppc_port
   import ppc_pkg::*;
#(
   parameter int               N            = ppc_pkg::PORT_WIDTH,
   parameter logic [15:0]      UART_SHARED  = ppc_pkg::DFLT_UART_SHARED,
   parameter logic [15:0]      TWI_SHARED   = ppc_pkg::DFLT_TWI_SHARED,
   parameter logic [15:0]      STBY_KEEP    = ppc_pkg::DFLT_STBY_KEEP,
   parameter int               WAKE_PIN     = ppc_pkg::DFLT_WAKE_PIN,
   parameter logic             WAKE_LEVEL   = ppc_pkg::DFLT_WAKE_LEVEL
)(
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        reset_n,
   // Wishbone slave
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [ppc_pkg::ADDR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [ppc_pkg::DATA_W-1:0]  wb_dat_i,
   output logic [ppc_pkg::DATA_W-1:0]       wb_dat_o,
   output logic                             wb_ack_o,
   // Pads
   input  wire logic [N-1:0]                pin_in,
   output logic [N-1:0]                     pin_out,
   output logic [N-1:0]                     pin_oe,
   output logic [N-1:0]                     pull_up_en,
   output logic [N-1:0]                     pull_dn_en,
   output logic [N-1:0]                     ttl_level_sel,
   output logic [N-1:0]                     analog_pin_input,
   // Alternate-function peripherals
   input  wire logic [N-1:0]                alt_dflt_out,
   input  wire logic [N-1:0]                alt_bsp_out,
   output logic [N-1:0]                     alt_dflt_in,
   output logic [N-1:0]                     alt_bsp_in,
   // Power management
   input  wire logic                        standby_i,
   output logic                             wake_req
);

   // ==========================================================
   // Registers
   logic [N-1:0] port_cfg_bit0_reg_r;
   logic [N-1:0] port_cfg_bit1_reg_r;
   logic [N-1:0] port_cfg_bit2_reg_r;
   logic [N-1:0] port_pin_data_reg_r;
   logic         boot_spi_en_r;
   logic         ack_r;
   logic [DATA_W-1:0] rdat_r;

   // Byte-lane merge shared by the cfg and data registers; the boot bit uses lane 0 directly
   function automatic logic [N-1:0] wb_merge(input logic [N-1:0]      old_v,
                                             input logic [DATA_W-1:0] wdat,
                                             input logic [3:0]        sel);
      logic [N-1:0] res;
      res = old_v;
      for (int b = 0; b < N; b++) begin
         if (sel[b/8]) begin
            res[b] = wdat[b];
         end
      end
      return res;
   endfunction : wb_merge

   // ==========================================================
   // Bus decode
   wire logic [7:0] adr_word = {wb_adr_i[7:2], 2'b00};
   wire logic       req      = wb_cyc_i & wb_stb_i;
   wire logic       wr_now   = req & wb_we_i & ack_r;
   wire logic       hit_cfg0 = (adr_word == OFF_CFG0);
   wire logic       hit_cfg1 = (adr_word == OFF_CFG1);
   wire logic       hit_cfg2 = (adr_word == OFF_CFG2);
   wire logic       hit_data = (adr_word == OFF_DATA);
   wire logic       hit_boot = (adr_word == OFF_BOOT);
   wire logic       hit_stat = (adr_word == OFF_STATUS);

   // ==========================================================
   // Per-pin decode
   logic [N-1:0] cell_val;
   logic [N-1:0] cell_oe;
   logic [N-1:0] cell_pu;
   logic [N-1:0] cell_pd;
   logic [N-1:0] cell_ttl;
   logic [N-1:0] cell_ana;
   logic [N-1:0] cell_rd;
   logic [N-1:0] alt_sel;
   logic [N-1:0] bsp_route;
   logic [N-1:0] shared_mask;

   // Shared pins stay with their default owner until the enable bit is set
   assign shared_mask = UART_SHARED[N-1:0] | TWI_SHARED[N-1:0];
   assign bsp_route   = shared_mask & {N{boot_spi_en_r}};
   assign alt_sel     = (bsp_route & alt_bsp_out) | (~bsp_route & alt_dflt_out);

   for (genvar i = 0; i < N; i++) begin : g_pin
      wire ppc_mode_e pin_mode = ppc_mode_e'({port_cfg_bit2_reg_r[i],
                                              port_cfg_bit1_reg_r[i],
                                              port_cfg_bit0_reg_r[i]});
      ppc_pin_cell u_cell (
         .mode         (pin_mode),
         .data_bit     (port_pin_data_reg_r[i]),
         .alt_bit      (alt_sel[i]),
         .pin_level    (pin_in[i]),
         .standby      (standby_i),
         .keep_in_stby (STBY_KEEP[i]),
         .input_only   (i == WAKE_PIN),
         .drv_val      (cell_val[i]),
         .drv_oe       (cell_oe[i]),
         .pull_up      (cell_pu[i]),
         .pull_dn      (cell_pd[i]),
         .ttl_lvl      (cell_ttl[i]),
         .analog       (cell_ana[i]),
         .rd_bit       (cell_rd[i])
      );
   end

   // ==========================================================
   // Read mux, unmapped addresses read zero
   wire logic [DATA_W-1:0] pad0 = '0;
   wire logic              wake_hit = standby_i & (pin_in[WAKE_PIN] == WAKE_LEVEL);
   wire logic [DATA_W-1:0] stat_word =
      pad0 | (DATA_W'(standby_i) << STAT_STBY_BIT) | (DATA_W'(wake_req) << STAT_WAKE_BIT);
   wire logic [DATA_W-1:0] rd_word =
      hit_cfg0 ? (pad0 | DATA_W'(port_cfg_bit0_reg_r)) :
      hit_cfg1 ? (pad0 | DATA_W'(port_cfg_bit1_reg_r)) :
      hit_cfg2 ? (pad0 | DATA_W'(port_cfg_bit2_reg_r)) :
      hit_data ? (pad0 | DATA_W'(cell_rd)) :
      hit_boot ? (pad0 | (DATA_W'(boot_spi_en_r) << BOOT_SPI_EN_BIT)) :
      hit_stat ? stat_word : pad0;

   // ==========================================================
   // Bus handshake: ack one cycle after the request, dropped after one
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ack_r  <= 1'b0;
         rdat_r <= '0;
      end else begin
         ack_r  <= req & ~ack_r;
         rdat_r <= rd_word;
      end
   end

   // Register writes take effect on the edge where the master sees ack
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         port_cfg_bit0_reg_r <= RST_CFG0[N-1:0];
         port_cfg_bit1_reg_r <= RST_CFG1[N-1:0];
         port_cfg_bit2_reg_r <= RST_CFG2[N-1:0];
         port_pin_data_reg_r <= RST_DATA[N-1:0];
         boot_spi_en_r       <= RST_BOOT_SPI_EN;
      end else if (wr_now) begin
         if (hit_cfg0) port_cfg_bit0_reg_r <= wb_merge(port_cfg_bit0_reg_r, wb_dat_i, wb_sel_i);
         if (hit_cfg1) port_cfg_bit1_reg_r <= wb_merge(port_cfg_bit1_reg_r, wb_dat_i, wb_sel_i);
         if (hit_cfg2) port_cfg_bit2_reg_r <= wb_merge(port_cfg_bit2_reg_r, wb_dat_i, wb_sel_i);
         if (hit_data) port_pin_data_reg_r <= wb_merge(port_pin_data_reg_r, wb_dat_i, wb_sel_i);
         if (hit_boot && wb_sel_i[0]) boot_spi_en_r <= wb_dat_i[BOOT_SPI_EN_BIT];
      end
   end

   // ==========================================================
   // Pad and peripheral outputs, all registered
   // Idle-high toward the peripheral that does not own the pin keeps its receiver quiet
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pin_out          <= '0;
         pin_oe           <= '0;
         pull_up_en       <= '0;
         pull_dn_en       <= '0;
         ttl_level_sel    <= '0;
         analog_pin_input <= '0;
         alt_dflt_in      <= '1;
         alt_bsp_in       <= '1;
         wake_req         <= 1'b0;
      end else begin
         pin_out          <= cell_val;
         pin_oe           <= cell_oe;
         pull_up_en       <= cell_pu;
         pull_dn_en       <= cell_pd;
         ttl_level_sel    <= cell_ttl;
         analog_pin_input <= cell_ana;
         alt_dflt_in      <= pin_in | bsp_route;
         alt_bsp_in       <= pin_in | ~bsp_route;
         wake_req         <= wake_hit;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // ==========================================================
   // Checks: modes on pin 0, then routing, standby, wake and bus ack
   // Checks wait one edge past reset release, so pad flops already hold live values
   logic live_r;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         live_r <= 1'b0;
      end else begin
         live_r <= 1'b1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!live_r);

   wire ppc_mode_e m0 = ppc_mode_e'({port_cfg_bit2_reg_r[0], port_cfg_bit1_reg_r[0],
                                     port_cfg_bit0_reg_r[0]});
   wire logic run0 = !standby_i;

   property p_ttl_float;
      (m0 == MODE_TTL_FLOAT) && run0 |=>
         ttl_level_sel[0] && !pin_oe[0] && !pull_up_en[0] && !pull_dn_en[0];
   endproperty
   a_ttl_float: assert property (p_ttl_float) else $error("ttl float mode wrong");

   property p_cmos_float;
      (m0 == MODE_CMOS_FLOAT) && run0 |=>
         !ttl_level_sel[0] && !pin_oe[0] && !pull_up_en[0] && !analog_pin_input[0];
   endproperty
   a_cmos_float: assert property (p_cmos_float) else $error("cmos float mode wrong");

   property p_pull_dn;
      (m0 == MODE_IN_PULL) && !port_pin_data_reg_r[0] && run0 |=>
         pull_dn_en[0] && !pull_up_en[0] && !pin_oe[0];
   endproperty
   a_pull_dn: assert property (p_pull_dn) else $error("pull-down not applied");

   property p_pull_up;
      (m0 == MODE_IN_PULL) && port_pin_data_reg_r[0] && run0 |=>
         pull_up_en[0] && !pull_dn_en[0] && !pin_oe[0];
   endproperty
   a_pull_up: assert property (p_pull_up) else $error("pull-up not applied");

   property p_analog;
      (m0 == MODE_ANALOG) |-> !cell_rd[0] ##1 analog_pin_input[0] && !pin_oe[0];
   endproperty
   a_analog: assert property (p_analog) else $error("analog pin not isolated");

   property p_open_drain;
      (m0 == MODE_OUT_OD) && run0 |=>
         !pin_out[0] && (pin_oe[0] == !$past(port_pin_data_reg_r[0]));
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open-drain drive wrong");

   property p_push_pull;
      (m0 == MODE_OUT_PP) && run0 |-> (cell_rd[0] == port_pin_data_reg_r[0])
         ##1 pin_oe[0] && (pin_out[0] == $past(port_pin_data_reg_r[0]));
   endproperty
   a_push_pull: assert property (p_push_pull) else $error("push-pull drive wrong");

   property p_alt_pp;
      (m0 == MODE_ALT_PP) && run0 |=> pin_oe[0] && (pin_out[0] == $past(alt_sel[0]));
   endproperty
   a_alt_pp: assert property (p_alt_pp) else $error("alternate push-pull wrong");

   property p_alt_od;
      (m0 == MODE_ALT_OD) && run0 |=>
         !pin_out[0] && (pin_oe[0] == !$past(alt_sel[0]));
   endproperty
   a_alt_od: assert property (p_alt_od) else $error("alternate open-drain wrong");

   // While the enable bit is clear, shared pins take data from and hand levels to the default owner
   property p_uart_twi;
      !boot_spi_en_r |-> ((alt_sel & shared_mask) == (alt_dflt_out & shared_mask))
         ##1 (alt_dflt_in == $past(pin_in));
   endproperty
   a_uart_twi: assert property (p_uart_twi) else $error("route wrong");

   property p_default_route;
      !boot_spi_en_r |=> ((alt_bsp_in & shared_mask) == shared_mask);
   endproperty
   a_default_route: assert property (p_default_route) else $error("serial port got pins");

   property p_standby;
      standby_i |=> ((pin_oe & ~STBY_KEEP[N-1:0]) == '0);
   endproperty
   a_standby: assert property (p_standby) else $error("pin driven in standby");

   property p_stby_pull;
      standby_i |=> (((pull_up_en | pull_dn_en) & ~STBY_KEEP[N-1:0]) == '0);
   endproperty
   a_stby_pull: assert property (p_stby_pull) else $error("pull left on in standby");

   property p_wake;
      (!pin_oe[WAKE_PIN]) and (wake_hit |=> wake_req);
   endproperty
   a_wake: assert property (p_wake) else $error("wake pin misbehaves");

   property p_ack;
      req && !ack_r |=> ack_r ##1 !ack_r;
   endproperty
   a_ack: assert property (p_ack) else $error("bus ack timing wrong");

   c_write_data: cover property (wr_now && hit_data);
   c_spi_enable: cover property ($rose(boot_spi_en_r));
   c_standby:    cover property (standby_i && (m0 == MODE_OUT_PP));
   c_wake:       cover property ($rose(wake_req));
   c_alt_od:     cover property ((m0 == MODE_ALT_OD) && run0);

endmodule : ppc_port

`default_nettype wire

// ==== sim/ppc_pad_model.sv ====
// Behavioural model of the board circuitry seen by the port pads
`default_nettype none

module ppc_pad_model #(
   parameter int N = 16
)(
   // Clock for the floating-pin pattern
   input  wire logic         core_clk,
   // Pad controls from the port
   input  wire logic [N-1:0] pin_out,
   input  wire logic [N-1:0] pin_oe,
   input  wire logic [N-1:0] pull_up_en,
   input  wire logic [N-1:0] pull_dn_en,
   // External drivers on the board
   input  wire logic [N-1:0] ext_val,
   input  wire logic [N-1:0] ext_en,
   // Resolved pad levels
   output logic [N-1:0]      pin_in
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [N-1:0] last_r = '0;

   // ==========================================================
   // Pad wins, then board driver, then weak pulls, else floating
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pull_up_en[i]) pin_in[i] = 1'b1;
         else if (pull_dn_en[i]) pin_in[i] = 1'b0;
         else pin_in[i] = ~last_r[i];                    // Floating: no stable level
      end
   end

   // Remember the level so a released pin keeps changing
   always_ff @(posedge core_clk) begin
      last_r <= pin_in;
   end

endmodule : ppc_pad_model

`default_nettype wire

// ==== sim/ppc_port_tb.sv ====
// Self-checking testbench of the port pin configuration block
`default_nettype none

module ppc_port_tb;
   import ppc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, standby_i, wake_req;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [15:0] pin_in, pin_out, pin_oe, pull_up_en, pull_dn_en, ttl_level_sel, analog_pin_input;
   logic [15:0] alt_dflt_out, alt_bsp_out, alt_dflt_in, alt_bsp_in, ext_val, ext_en;
   int          err_total, compares, cycles;
   // Expected read-back and driver enables per mode, data 80ff, board 0f0f, alt 3c3c
   logic [15:0] exp_rd [8] = '{16'h0000, 16'h0f0f, 16'h0f0f, 16'h80ff,
                               16'h000f, 16'h80ff, 16'h0c0c, 16'h3c3c};
   logic [15:0] exp_oe [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                               16'h7f00, 16'h7fff, 16'h43c3, 16'h7fff};

   // ==========================================================
   // Design and board; pin 4 stays live in standby to test the exception
   ppc_port #(.STBY_KEEP(16'h0010)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
      .pull_dn_en(pull_dn_en), .ttl_level_sel(ttl_level_sel),
      .analog_pin_input(analog_pin_input), .alt_dflt_out(alt_dflt_out),
      .alt_bsp_out(alt_bsp_out), .alt_dflt_in(alt_dflt_in), .alt_bsp_in(alt_bsp_in),
      .standby_i(standby_i), .wake_req(wake_req));
   ppc_pad_model #(.N(16)) u_pads (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .ext_val(ext_val), .ext_en(ext_en),
      .pin_in(pin_in));

   // ==========================================================
   // Clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         wrap_up();
      end
   end

   // Classic cycle; ack and read data are taken at the rising edge where ack is high
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= wd;
      do @(posedge core_clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb_xfer

   task automatic chk_reg(input logic [7:0] adr, input logic [31:0] exp, input string msg);
      wb_xfer(1'b0, adr, 32'h0000_0000);
      compares++;
      if (rd !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s read %h expected %h", $time, msg, rd, exp);
      end
   endtask : chk_reg

   task automatic chk_pad(input logic [15:0] got, input logic [15:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s is %h expected %h", $time, msg, got, exp);
      end
   endtask : chk_pad

   // Pad outputs are registered, so let two edges pass after a change
   task automatic settle();
      repeat (2) @(negedge core_clk);
   endtask : settle

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   // ==========================================================
   // Main sequence
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, standby_i, reset_n} = 5'b00000;
      {wb_adr_i, wb_sel_i, wb_dat_i, rd} = '0;
      {err_total, compares, cycles} = '0;
      alt_dflt_out = 16'h3c3c;
      alt_bsp_out  = 16'hc3c3;
      ext_val      = 16'h0f0f;
      ext_en       = 16'hffff;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      // Reset map, unmapped place
      settle();
      chk_reg(OFF_CFG0, 32'h0000_ffff, "cfg0");
      chk_reg(OFF_CFG1, 32'h0000_ffff, "cfg1");
      chk_reg(OFF_CFG2, 32'h0000_0000, "cfg2");
      chk_reg(OFF_BOOT, 32'h0000_0000, "boot");
      chk_reg(8'h18, 32'h0000_0000, "unmapped");
      $display("test reset done");
      // Every mode on all pins; per-pin data picks pulls and drivers
      wb_xfer(1'b1, OFF_DATA, 32'h0000_80ff);
      for (int m = 0; m < 8; m++) begin
         ext_en <= (m == 3) ? 16'h0000 : 16'hffff;
         wb_xfer(1'b1, OFF_CFG0, {16'h0, {16{m[0]}}});
         wb_xfer(1'b1, OFF_CFG1, {16'h0, {16{m[1]}}});
         wb_xfer(1'b1, OFF_CFG2, {16'h0, {16{m[2]}}});
         settle();
         chk_reg(OFF_DATA, {16'h0, exp_rd[m]}, "data read");
         chk_pad(pin_oe, exp_oe[m], "pin_oe");
         chk_pad(analog_pin_input, (m == 0) ? 16'hffff : 16'h0, "analog");
         chk_pad(ttl_level_sel, (m == 1) ? 16'hffff : 16'h0, "ttl");
         chk_pad(pull_up_en, (m == 3) ? 16'h80ff : 16'h0, "pull up");
         chk_pad(pull_dn_en, (m == 3) ? 16'h7f00 : 16'h0, "pull down");
      end
      chk_pad(pin_out & 16'h7fff, 16'h3c3c, "alt default out");
      chk_pad(alt_bsp_in, 16'hffff, "serial in idle");
      $display("test modes done");
      // Serial port enable moves shared pins 0..3 over
      wb_xfer(1'b1, OFF_BOOT, 32'h0000_0001);
      settle();
      chk_reg(OFF_BOOT, 32'h0000_0001, "boot set");
      chk_pad(pin_out & 16'h7fff, 16'h3c33, "serial out");
      chk_pad(alt_bsp_in, 16'hfff3, "serial in");
      chk_pad(alt_dflt_in, 16'h3c3f, "default in");
      $display("test routing done");
      // Standby releases all but the kept pin; wake pin raises a request
      standby_i <= 1'b1;
      settle();
      chk_pad(pin_oe, 16'h0010, "standby oe");
      chk_pad({15'h0, wake_req}, 16'h0000, "wake idle");
      ext_val <= 16'h8f0f;
      settle();
      chk_pad({15'h0, wake_req}, 16'h0001, "wake");
      wb_xfer(1'b1, OFF_STATUS, 32'h0000_0000);
      chk_reg(OFF_STATUS, 32'h0000_0003, "status");
      $display("test standby done");
      wrap_up();
   end

endmodule : ppc_port_tb

`default_nettype wire
